// *** inc/adcpc_defs.svh ***
/*
 Constants for the parallel-port converter control block: control byte
 field positions, reset values and timing counts.
 Assumes a 40 MHz system clock.
*/
`ifndef ADCPC_DEFS_SVH
`define ADCPC_DEFS_SVH

`define ADCPC_CLK_PERIOD_PS     25000
`define ADCPC_BIT_PWR_HI        7
`define ADCPC_BIT_PWR_LO        6
`define ADCPC_BIT_ACQ           5
`define ADCPC_BIT_SGL           4
`define ADCPC_BIT_UNI           3
`define ADCPC_CHAN_MSB          2
`define ADCPC_CTRL_RESET        8'hc8
`define ADCPC_CONV_TIME_NS      3600
`define ADCPC_CONV_CYCLES       13
`define ADCPC_ACQ_CYCLES        3
`define ADCPC_INT_DIV           ((`ADCPC_CONV_TIME_NS * 1000) / (`ADCPC_CONV_CYCLES * `ADCPC_CLK_PERIOD_PS))
`define ADCPC_FIFO_DEPTH        16

`endif

// *** inc/adcpc_pkg.sv ***
/*
 Types of the parallel-port converter control block.
 Assumes adcpc_defs.svh is available.
*/
package adcpc_pkg;
  typedef enum logic [2:0] {
    ADCPC_IDLE,
    ADCPC_ACQ_EXT,
    ADCPC_ACQ_INT,
    ADCPC_CONV
  } adcpc_state_t;
endpackage : adcpc_pkg

// *** src/adcpc_fifo.sv ***
/*
 Parameterised flip-flop FIFO with valid and ready on both sides.
 Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module adcpc_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : adcpc_fifo

// *** src/adcpc_top.sv ***
/*
 Digital control of a 10-bit converter behind a byte-wide parallel port:
 control byte capture, clock and power modes, acquisition and conversion
 sequencing, conversion-done flag and two-byte result readout.
 Assumes all pins synchronous to clk_sys; the analog core returns a raw
 offset-binary code on sar_code when a conversion ends.
*/
`timescale 1ns/1ps
`include "adcpc_defs.svh"
module adcpc_top (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       cs_n,
  input  wire logic       wr_n,
  input  wire logic       rd_n,
  input  wire logic       upper_byte_select,
  input  wire logic       ext_clk,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  output logic            done_n,
  output logic            done_oe,
  output logic            sample_hold,
  output logic            core_powered,
  output logic            standby,
  output logic      [7:0] pos_input_sel,
  output logic            neg_common,
  output logic      [7:0] neg_input_sel,
  output logic            sar_step,
  input  wire logic [9:0] sar_code
);
  //////////////////////////////////////////////////////////////////////////
  // Port strobes
  logic [7:0] ctrl;
  logic       clk_internal;
  logic       shutdown;
  logic       shutdown_pending;
  logic       wr_q;
  logic       rd_q;
  logic       ext_q;
  logic       wr_rise;
  logic       rd_fall;
  logic       tick;
  logic [7:0] div_cnt;
  logic [3:0] cyc_cnt;
  logic       conv_end;
  logic [9:0] result;
  logic       res_valid;
  logic [9:0] fifo_data;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic [9:0] formatted;
  logic       rd_active;
  adcpc_pkg::adcpc_state_t state;
  adcpc_pkg::adcpc_state_t next_state;

  // Strobes and clock are seen only while selected
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= 1'b1;
      rd_q  <= 1'b1;
      ext_q <= 1'b0;
    end else begin
      wr_q  <= wr_n | cs_n;
      rd_q  <= rd_n | cs_n;
      ext_q <= ext_clk & ~cs_n;
    end
  end

  assign wr_rise   = (wr_n | cs_n) && !wr_q;
  assign rd_active = !cs_n && !rd_n;
  assign rd_fall   = rd_active && rd_q;

  //////////////////////////////////////////////////////////////////////////
  // Control byte and modes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl         <= `ADCPC_CTRL_RESET;
      clk_internal <= 1'b0;
    end else if (wr_rise) begin
      ctrl <= data_in;
      if (data_in[`ADCPC_BIT_PWR_HI]) begin
        clk_internal <= !data_in[`ADCPC_BIT_PWR_LO];
      end
    end
  end

  // Power state: standby lifts at next write, shutdown waits for conversion
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      standby          <= 1'b0;
      shutdown         <= 1'b0;
      shutdown_pending <= 1'b0;
    end else if (wr_rise) begin
      standby          <= data_in[7:6] == 2'b01;
      shutdown         <= 1'b0;
      shutdown_pending <= data_in[7:6] == 2'b00;
    end else if (shutdown_pending && state != adcpc_pkg::ADCPC_CONV) begin
      shutdown         <= 1'b1;
      shutdown_pending <= 1'b0;
    end
  end

  assign core_powered = !shutdown && !standby;

  //////////////////////////////////////////////////////////////////////////
  // Conversion clock: internal divider or external pin edges
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 8'h00;
    end else if (wr_rise || div_cnt == 8'(`ADCPC_INT_DIV - 1)) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  always_comb begin
    if (clk_internal) begin
      tick = div_cnt == 8'(`ADCPC_INT_DIV - 1);
    end else begin
      tick = (ext_clk & ~cs_n) && !ext_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Acquisition and conversion sequencing
  always_comb begin
    next_state = state;
    case (state)
      adcpc_pkg::ADCPC_IDLE: begin
        next_state = state;
      end
      adcpc_pkg::ADCPC_ACQ_INT: begin
        if (tick && cyc_cnt == 4'(`ADCPC_ACQ_CYCLES - 1)) begin
          next_state = adcpc_pkg::ADCPC_CONV;
        end
      end
      adcpc_pkg::ADCPC_ACQ_EXT: begin
        next_state = state;
      end
      adcpc_pkg::ADCPC_CONV: begin
        if (conv_end) begin
          next_state = adcpc_pkg::ADCPC_IDLE;
        end
      end
      default: begin
        next_state = adcpc_pkg::ADCPC_IDLE;
      end
    endcase
    // A new byte restarts or stops the sequence, or ends an external acquisition
    if (wr_rise) begin
      // Power-down bytes start no conversion unless they end an external acquisition
      if (!data_in[`ADCPC_BIT_PWR_HI] &&
          state != adcpc_pkg::ADCPC_ACQ_EXT) begin
        next_state = adcpc_pkg::ADCPC_IDLE;
      end else if (data_in[`ADCPC_BIT_ACQ]) begin
        next_state = adcpc_pkg::ADCPC_ACQ_EXT;
      end else if (state == adcpc_pkg::ADCPC_ACQ_EXT) begin
        next_state = adcpc_pkg::ADCPC_CONV;
      end else begin
        next_state = adcpc_pkg::ADCPC_ACQ_INT;
      end
    end
    if (shutdown && !wr_rise) begin
      next_state = adcpc_pkg::ADCPC_IDLE;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= adcpc_pkg::ADCPC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cyc_cnt <= 4'h0;
    end else if (state != next_state) begin
      cyc_cnt <= 4'h0;
    end else if (tick) begin
      cyc_cnt <= cyc_cnt + 4'h1;
    end
  end

  assign conv_end    = state == adcpc_pkg::ADCPC_CONV && tick &&
                       cyc_cnt == 4'(`ADCPC_CONV_CYCLES - 1) && !wr_rise;
  assign sar_step    = state == adcpc_pkg::ADCPC_CONV && tick;
  assign sample_hold = state == adcpc_pkg::ADCPC_CONV;

  //////////////////////////////////////////////////////////////////////////
  // Input multiplexer decode
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_mux
      always_comb begin
        if (ctrl[`ADCPC_BIT_SGL]) begin
          pos_input_sel[gi] = ctrl[2:0] == 3'(gi);
          neg_input_sel[gi] = 1'b0;
        end else begin
          pos_input_sel[gi] = ctrl[2:1] == 2'(gi / 2) &&
                              ctrl[0] == 1'(gi % 2);
          neg_input_sel[gi] = ctrl[2:1] == 2'(gi / 2) &&
                              ctrl[0] != 1'(gi % 2);
        end
      end
    end
  endgenerate
  assign neg_common = ctrl[`ADCPC_BIT_SGL];

  //////////////////////////////////////////////////////////////////////////
  // Result path through the FIFO
  // Core code steps VREF/1024; bipolar flips the MSB into two's complement
  assign formatted = ctrl[`ADCPC_BIT_UNI] ? sar_code
                                          : {~sar_code[9], sar_code[8:0]};

  adcpc_fifo #(
    .WIDTH (10),
    .DEPTH (`ADCPC_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (conv_end),
    .in_ready  (fifo_in_ready),
    .in_data   (formatted),
    .out_valid (fifo_out_valid),
    .out_ready (1'b1),
    .out_data  (fifo_data)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      result    <= 10'h000;
      res_valid <= 1'b0;
    end else if (fifo_out_valid) begin
      result    <= fifo_data;
      res_valid <= 1'b1;
    end else if (rd_fall || wr_rise) begin
      res_valid <= 1'b0;
    end
  end

  // Done flag; a new result beats a same-cycle clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      done_n <= 1'b1;
    end else if (fifo_out_valid) begin
      done_n <= 1'b0;
    end else if (rd_fall || wr_rise) begin
      done_n <= 1'b1;
    end
  end
  assign done_oe = !cs_n;

  //////////////////////////////////////////////////////////////////////////
  // Read data bus
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= 8'h00;
    end else if (upper_byte_select) begin
      data_out <= {{6{result[9] & ~ctrl[`ADCPC_BIT_UNI]}}, result[9:8]};
    end else begin
      data_out <= result[7:0];
    end
  end
  assign data_oe = rd_active;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  property p_reset_ext;
    @(posedge clk_sys) $rose(rst_n) |-> !clk_internal && done_n;
  endproperty
  a_reset_ext: assert property (p_reset_ext) else $error("reset mode wrong");

  property p_pd_keeps_clk;
    @(posedge clk_sys) disable iff (!rst_n)
      wr_rise && !data_in[7] |=> $stable(clk_internal);
  endproperty
  a_pd_keeps_clk: assert property (p_pd_keeps_clk) else $error("clock mode changed");

  property p_clk_sel;
    @(posedge clk_sys) disable iff (!rst_n)
      wr_rise && data_in[7] |=> clk_internal == !$past(data_in[6]);
  endproperty
  a_clk_sel: assert property (p_clk_sel) else $error("clock select wrong");

  property p_bus_float;
    @(posedge clk_sys) disable iff (!rst_n) cs_n |-> !data_oe && !done_oe;
  endproperty
  a_bus_float: assert property (p_bus_float) else $error("bus driven");

  property p_ctrl_cap;
    @(posedge clk_sys) disable iff (!rst_n) wr_rise |=> ctrl == $past(data_in);
  endproperty
  a_ctrl_cap: assert property (p_ctrl_cap) else $error("control not captured");

  property p_upper;
    @(posedge clk_sys) disable iff (!rst_n)
      upper_byte_select |=>
      data_out[7:2] == ($past(ctrl[3]) ? 6'h00 : {6{$past(result[9])}});
  endproperty
  a_upper: assert property (p_upper) else $error("upper byte wrong");

  property p_done;
    @(posedge clk_sys) disable iff (!rst_n) fifo_out_valid |=> !done_n;
  endproperty
  a_done: assert property (p_done) else $error("done not asserted");

  property p_no_conv_pd;
    @(posedge clk_sys) disable iff (!rst_n) shutdown |-> !sar_step;
  endproperty
  a_no_conv_pd: assert property (p_no_conv_pd) else $error("conversion in shutdown");
endmodule : adcpc_top

// *** verif/adcpc_host.sv ***
/*
 Host processor model on the byte-wide port: control writes and result reads.
 Assumes clk_sys is shared with the device and strobes are sampled on its edges.
*/
`timescale 1ns/1ps
module adcpc_host (
  input  wire logic       clk_sys,
  output logic            cs_n,
  output logic            wr_n,
  output logic            rd_n,
  output logic            upper_byte_select,
  output logic      [7:0] data_in,
  input  wire logic [7:0] data_out
);
  logic park_n;
  initial begin
    park_n = 1'b1;
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    upper_byte_select = 1'b0;
    data_in = 8'h00;
  end
  task automatic park(input logic v);
    @(posedge clk_sys);
    park_n = v;
    cs_n <= v;
  endtask : park
  // Released data lines show the inverse of the last byte
  task automatic write_ctrl(input logic [7:0] b, input logic sel);
    @(posedge clk_sys);
    cs_n <= ~sel;
    wr_n <= 1'b0;
    data_in <= b;
    repeat (2) @(posedge clk_sys);
    wr_n <= 1'b1;
    @(posedge clk_sys);
    cs_n <= park_n;
    data_in <= ~b;
    #1;
  endtask : write_ctrl
  task automatic read_byte(input logic hi, output logic [7:0] d);
    @(posedge clk_sys);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    upper_byte_select <= hi;
    repeat (2) @(posedge clk_sys);
    #1;
    d = data_out;
    @(posedge clk_sys);
    rd_n <= 1'b1;
    cs_n <= park_n;
    upper_byte_select <= ~hi;
  endtask : read_byte
endmodule : adcpc_host

// *** verif/tb_adcpc_top.sv ***
/*
 Self-checking bench of the converter control block: reset and chip select,
 then a table of conversions, abort, acquisition and power-down cases.
 Assumes the host model drives the port and the bench plays the analog core.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb_adcpc_top;
  typedef struct {logic [7:0] ctrl; logic [9:0] code; logic [7:0] pos, neg;} adcpc_row_t;
  logic       clk_sys, rst_n, ext_clk, ext_run, cs_n, wr_n, rd_n, upper_byte_select;
  logic [7:0] data_in, data_out, pos_input_sel, neg_input_sel, rd_lo, rd_hi;
  logic       data_oe, done_n, done_oe, sample_hold, core_powered, standby;
  logic       neg_common, sar_step;
  logic [9:0] sar_code, exp;
  int         n_mismatch, checks_done, t;
  adcpc_row_t rows [8] = '{'{8'h98, 10'h3ff, 8'h01, 8'h00}, '{8'h93, 10'h2a5, 8'h08, 8'h00},
    '{8'h9d, 10'h000, 8'h20, 8'h00}, '{8'h97, 10'h155, 8'h80, 8'h00},
    '{8'h88, 10'h201, 8'h01, 8'h02}, '{8'h81, 10'h0f0, 8'h02, 8'h01},
    '{8'h8e, 10'h1c3, 8'h40, 8'h80}, '{8'h83, 10'h37e, 8'h08, 8'h04}};
  adcpc_host u_host (.clk_sys(clk_sys), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .upper_byte_select(upper_byte_select), .data_in(data_in), .data_out(data_out));
  adcpc_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .upper_byte_select(upper_byte_select), .ext_clk(ext_clk), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .done_n(done_n), .done_oe(done_oe),
    .sample_hold(sample_hold), .core_powered(core_powered), .standby(standby),
    .pos_input_sel(pos_input_sel), .neg_common(neg_common), .neg_input_sel(neg_input_sel),
    .sar_step(sar_step), .sar_code(sar_code));
  ////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    ext_clk = 1'b0;
    forever begin
      repeat (8) @(posedge clk_sys);
      if (ext_run) ext_clk <= ~ext_clk;
    end
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    give_verdict();
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  task automatic wait_done(input int lim);
    for (t = 0; t < lim && done_n !== 1'b0; t++) @(posedge clk_sys) #1;
  endtask : wait_done
  ////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    ext_run = 1'b0;
    sar_code = 10'h2c6;
    n_mismatch = 0;
    checks_done = 0;
    repeat (8) @(posedge clk_sys);
    `CHK("done_n", 1'b1, done_n)
    `CHK("data_oe", 1'b0, data_oe)
    `CHK("done_oe", 1'b0, done_oe)
    rst_n <= 1'b1;
    repeat (400) @(posedge clk_sys);
    u_host.write_ctrl(8'hd8, 1'b1);
    wait_done(300);
    `CHK("done_n", 1'b1, done_n)
    u_host.park(1'b0);
    ext_run = 1'b1;
    wait_done(400);
    `CHK("done_n", 1'b0, done_n)
    `CHK("done_oe", 1'b1, done_oe)
    ext_run = 1'b0;
    u_host.park(1'b1);
    u_host.write_ctrl(8'h9f, 1'b0);
    `CHK("pos_input_sel", 8'h01, pos_input_sel)
    `CHK("done_n", 1'b0, done_n)
    $display("test reset and select done");
    foreach (rows[i]) begin
      sar_code <= rows[i].code;
      u_host.write_ctrl(rows[i].ctrl, 1'b1);
      `CHK("done_n", 1'b1, done_n)
      `CHK("pos_input_sel", rows[i].pos, pos_input_sel)
      `CHK("neg_input_sel", rows[i].neg, neg_input_sel)
      `CHK("neg_common", rows[i].ctrl[4], neg_common)
      wait_done(400);
      `CHK("done_n", 1'b0, done_n)
      `CHK("conv time", 1'b1, (t >= 160 && t <= 190))
      exp = rows[i].ctrl[3] ? rows[i].code : {~rows[i].code[9], rows[i].code[8:0]};
      sar_code <= ~rows[i].code;
      u_host.read_byte(1'b0, rd_lo);
      `CHK("done_n", 1'b1, done_n)
      u_host.read_byte(1'b1, rd_hi);
      `CHK("low byte", exp[7:0], rd_lo)
      `CHK("high byte", {{6{~rows[i].ctrl[3] & exp[9]}}, exp[9:8]}, rd_hi)
      $display("test row %0d done", i);
    end
    sar_code <= 10'h123;
    u_host.write_ctrl(8'h98, 1'b1);
    repeat (100) @(posedge clk_sys);
    u_host.write_ctrl(8'h9a, 1'b1);
    wait_done(150);
    `CHK("done_n", 1'b1, done_n)
    wait_done(100);
    `CHK("done_n", 1'b0, done_n)
    `CHK("pos_input_sel", 8'h04, pos_input_sel)
    u_host.read_byte(1'b0, rd_lo);
    `CHK("low byte", 8'h23, rd_lo)
    $display("test abort done");
    sar_code <= 10'h0aa;
    u_host.write_ctrl(8'hba, 1'b1);
    wait_done(300);
    `CHK("done_n", 1'b1, done_n)
    `CHK("sample_hold", 1'b0, sample_hold)
    u_host.write_ctrl(8'h9a, 1'b1);
    wait_done(200);
    `CHK("done_n", 1'b0, done_n)
    u_host.read_byte(1'b0, rd_lo);
    `CHK("low byte", 8'haa, rd_lo)
    $display("test open acquisition done");
    sar_code <= 10'h055;
    u_host.write_ctrl(8'h5a, 1'b1);
    `CHK("standby", 1'b1, standby)
    `CHK("core_powered", 1'b0, core_powered)
    wait_done(300);
    `CHK("done_n", 1'b1, done_n)
    u_host.read_byte(1'b0, rd_lo);
    `CHK("low byte", 8'haa, rd_lo)
    u_host.write_ctrl(8'h9a, 1'b1);
    `CHK("standby", 1'b0, standby)
    `CHK("core_powered", 1'b1, core_powered)
    wait_done(300);
    `CHK("done_n", 1'b0, done_n)
    u_host.read_byte(1'b0, rd_lo);
    $display("test standby done");
    u_host.write_ctrl(8'h1a, 1'b1);
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("core_powered", 1'b0, core_powered)
    `CHK("standby", 1'b0, standby)
    wait_done(300);
    `CHK("done_n", 1'b1, done_n)
    repeat (2000) @(posedge clk_sys);
    u_host.write_ctrl(8'h9a, 1'b1);
    `CHK("core_powered", 1'b1, core_powered)
    wait_done(300);
    `CHK("done_n", 1'b0, done_n)
    $display("test shutdown done");
    give_verdict();
  end
endmodule : tb_adcpc_top
